// File: hdl/loop_fetch_pkg.sv
// Constants, carrier types and shared decode helpers for the loop-mode fetch control.
// Functional notes
// - In loop mode hold looped word and both branch words, issue no opcode fetches.
// - Outside loop mode every opcode fetch proceeds normally, five bus cycles per pass.
// - Loop mode is entered automatically, without any software control.
// - Entry needs branch taken, displacement minus four, eligible one-word target just before.
// - Looped word and branch word are fetched twice; second fetch arms loop mode.
// - Once in loop mode, no instruction fetches until count exhausted or condition true.
// - Interrupt, trace, reset operation or bus error also ends loop mode.
// - In loop mode a pending interrupt is taken only after the branch, never after the looped instruction.
// - Taking an interrupt ends loop mode; later entry uses the normal sequence again.
// - With trace enabled, trace after both instructions, so loop mode never engages.
// - A reset operation aborts everything at once, including a loop iteration; the code still issues br_res_o for a branch executed in that cycle.
// - Bus error exits as normal; resuming the looped instruction needs no loop refetch.
// - Only one-word encodings with indirect, postincrement or predecrement operands qualify.
// - Eligible set: moves, arithmetic, logic, compare, decimal, extended, unary, memory shifts.
// - Branch decrements count low word; minus one stores and falls through; else condition decides.
package loop_fetch_pkg;

	// ********************************************************************
	// Encodings and constants
	// ********************************************************************
	localparam logic [15:0] LOOP_DISP      = 16'hFFFC;
	localparam logic [15:0] COUNT_END      = 16'hFFFF;
	localparam logic [15:0] COUNT_STEP     = 16'h0001;
	localparam logic [3:0]  DTB_LINE       = 4'h5;
	localparam logic [4:0]  DTB_SUBCODE    = 5'b1_1001;
	localparam logic [2:0]  EA_IND         = 3'h2;
	localparam logic [2:0]  EA_POSTINC     = 3'h3;
	localparam logic [2:0]  EA_PREDEC      = 3'h4;
	localparam logic [15:0] WORD_RST       = 16'h0000;

	typedef enum logic [2:0] {
		S_IDLE      = 3'b000,
		S_CAND      = 3'b001,
		S_DISP      = 3'b010,
		S_ARMED     = 3'b011,
		S_REFETCH_L = 3'b100,
		S_REFETCH_B = 3'b101,
		S_LOOP      = 3'b110
	} loop_state_t;

	// One opcode word returned by an instruction fetch bus cycle.
	typedef struct packed {
		logic        valid;
		logic [15:0] word;
	} fetch_t;

	// Decrement-test-branch execution request from the sequencer.
	typedef struct packed {
		logic        exec;
		logic        cond_true;
		logic [15:0] count;
	} branch_t;

	// Result of one decrement-test-branch execution.
	typedef struct packed {
		logic        valid;
		logic        count_we;
		logic        taken;
		logic [15:0] count;
	} branch_res_t;

	// ********************************************************************
	// Helpers
	// ********************************************************************
	// True for the first word of a decrement-test-branch instruction.
	function automatic logic is_dtb(input logic [15:0] w);
		is_dtb = (w[15:12] == DTB_LINE) && (w[7:3] == DTB_SUBCODE);
	endfunction

	// True for the three address-register-indirect memory modes.
	function automatic logic is_ind_mode(input logic [2:0] m);
		is_ind_mode = (m == EA_IND) || (m == EA_POSTINC) || (m == EA_PREDEC);
	endfunction

endpackage

// File: hdl/loop_eligible_dec.sv
// Combinational classifier for one-word instructions that may run in loop mode.
`timescale 1ns/100ps
`default_nettype none
module loop_eligible_dec (
	input  wire logic [15:0] word_i,
	output logic             eligible_o
);

	// ********************************************************************
	// Opcode classification
	// ********************************************************************
	logic [3:0] line;
	logic [2:0] opm;
	logic [2:0] mode;
	logic [2:0] dmode;
	logic [1:0] sz;

	assign line  = word_i[15:12];
	assign opm   = word_i[8:6];
	assign mode  = word_i[5:3];
	assign dmode = word_i[8:6];
	assign sz    = word_i[7:6];

	// Every accepted form is a single word; anything needing extension words is refused.
	always_comb begin
		eligible_o = 1'b0;
		case (line)
			4'h1, 4'h2, 4'h3: begin
				eligible_o = loop_fetch_pkg::is_ind_mode(dmode) &&
					(loop_fetch_pkg::is_ind_mode(mode) ||
					((mode[2:1] == 2'b00) && (dmode == loop_fetch_pkg::EA_POSTINC)));
			end
			4'h4: begin
				if ((word_i[11:8] == 4'h0 || word_i[11:8] == 4'h2 || word_i[11:8] == 4'h4 ||
						word_i[11:8] == 4'h6 || word_i[11:8] == 4'hA) && (sz != 2'b11)) begin
					eligible_o = loop_fetch_pkg::is_ind_mode(mode);
				end else if (word_i[11:6] == 6'b10_0000) begin
					eligible_o = loop_fetch_pkg::is_ind_mode(mode);
				end
			end
			// arithmetic, logic, compare, decimal and extended forms.
			4'h8, 4'h9, 4'hB, 4'hC, 4'hD: begin
				if (opm == 3'h3 || opm == 3'h7) begin
					eligible_o = (line != 4'h8) && (line != 4'hC) &&
						loop_fetch_pkg::is_ind_mode(mode);
				end else if (mode == 3'h1) begin
					eligible_o = (opm[2] && ((line == 4'hB) || (line == 4'h9) ||
						(line == 4'hD) || (opm == 3'h4)));
				end else begin
					eligible_o = loop_fetch_pkg::is_ind_mode(mode) &&
						!((line == 4'hB) && !opm[2]) || ((line == 4'hB) && !opm[2] &&
						loop_fetch_pkg::is_ind_mode(mode));
				end
			end
			// word memory shifts and rotates by one.
			4'hE: begin
				eligible_o = (word_i[11] == 1'b0) && (sz == 2'b11) &&
					loop_fetch_pkg::is_ind_mode(mode);
			end
			default: eligible_o = 1'b0;
		endcase
	end

endmodule // loop_eligible_dec
`default_nettype wire

// File: hdl/loop_fetch_ctrl.sv
// Loop-mode fetch controller: detects single-instruction loops and suppresses opcode fetches.
`timescale 1ns/100ps
`default_nettype none
module loop_fetch_ctrl (
	input  wire logic                         clk_i,
	input  wire logic                         rst_b_i,
	input  wire logic                         ce_i,
	input  wire loop_fetch_pkg::fetch_t       fetch_i,
	input  wire loop_fetch_pkg::branch_t      br_i,
	input  wire logic                         loop_done_i,
	input  wire logic                         irq_pend_i,
	input  wire logic                         trace_en_i,
	input  wire logic                         reset_op_i,
	input  wire logic                         bus_err_i,
	output logic                              loop_active_o,
	output logic                              refill_o,
	output logic                              irq_take_o,
	output logic                              trace_take_o,
	output logic [15:0]                       decode_o,
	output logic [31:0]                       queue_o,
	output loop_fetch_pkg::branch_res_t       br_res_o
);

	// ********************************************************************
	// Declarations
	// ********************************************************************
	loop_fetch_pkg::loop_state_t state_q;
	loop_fetch_pkg::loop_state_t state_d;
	logic                        elig;
	logic [15:0]                 cnt_dec;
	logic                        br_taken;
	logic                        capture_l;
	logic                        capture_b;
	logic                        capture_d;
	logic                        exit_ev;

	loop_eligible_dec u_dec (
		.word_i     (fetch_i.word),
		.eligible_o (elig)
	);

	// ********************************************************************
	// Branch arithmetic
	// ********************************************************************
	// decrement and decide.
	assign cnt_dec  = br_i.count - loop_fetch_pkg::COUNT_STEP;
	assign br_taken = (cnt_dec != loop_fetch_pkg::COUNT_END) && !br_i.cond_true;

	// ********************************************************************
	// Sequence detection
	// ********************************************************************
	// Reset operation beats bus error, which beats every ordinary transition.
	always_comb begin
		state_d   = state_q;
		capture_l = 1'b0;
		capture_b = 1'b0;
		capture_d = 1'b0;
		exit_ev   = 1'b0;
		case (state_q)
			loop_fetch_pkg::S_IDLE: begin
				if (fetch_i.valid && elig) begin
					capture_l = 1'b1;
					state_d   = loop_fetch_pkg::S_CAND;
				end
			end
			loop_fetch_pkg::S_CAND: begin
				if (fetch_i.valid) begin
					if (loop_fetch_pkg::is_dtb(fetch_i.word)) begin
						capture_b = 1'b1;
						state_d   = loop_fetch_pkg::S_DISP;
					end else if (elig) begin
						capture_l = 1'b1;
					end else begin
						state_d = loop_fetch_pkg::S_IDLE;
					end
				end
			end
			loop_fetch_pkg::S_DISP: begin
				if (fetch_i.valid) begin
					capture_d = 1'b1;
					state_d   = (fetch_i.word == loop_fetch_pkg::LOOP_DISP) ?
						loop_fetch_pkg::S_ARMED : loop_fetch_pkg::S_IDLE;
				end
			end
			// branch must loop and tracing must be off.
			loop_fetch_pkg::S_ARMED: begin
				if (br_i.exec) begin
					state_d = (br_taken && !trace_en_i && !irq_pend_i) ?
						loop_fetch_pkg::S_REFETCH_L : loop_fetch_pkg::S_IDLE;
				end
			end
			// second fetch of the looped word.
			loop_fetch_pkg::S_REFETCH_L: begin
				if (fetch_i.valid) begin
					state_d = (fetch_i.word == decode_o && elig && !trace_en_i) ?
						loop_fetch_pkg::S_REFETCH_B : loop_fetch_pkg::S_IDLE;
				end
			end
			// second fetch of the branch word enters loop mode.
			loop_fetch_pkg::S_REFETCH_B: begin
				if (fetch_i.valid) begin
					state_d = (fetch_i.word == queue_o[31:16] && !trace_en_i) ?
						loop_fetch_pkg::S_LOOP : loop_fetch_pkg::S_IDLE;
				end
			end
			// stay until exhausted, condition, interrupt or trace.
			loop_fetch_pkg::S_LOOP: begin
				if (br_i.exec && (!br_taken || irq_pend_i || trace_en_i)) begin
					exit_ev = 1'b1;
					state_d = loop_fetch_pkg::S_IDLE;
				end
			end
			default: state_d = loop_fetch_pkg::S_IDLE;
		endcase
		// bus error leaves loop mode like any other exception.
		if (bus_err_i) begin
			exit_ev = (state_q == loop_fetch_pkg::S_LOOP);
			state_d = loop_fetch_pkg::S_IDLE;
		end
		if (reset_op_i) begin
			exit_ev   = 1'b0;
			capture_l = 1'b0;
			capture_b = 1'b0;
			capture_d = 1'b0;
			state_d   = loop_fetch_pkg::S_IDLE;
		end
	end

	// State register and the registered loop flag that gates opcode fetches.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q       <= loop_fetch_pkg::S_IDLE;
			loop_active_o <= 1'b0;
		end else if (ce_i) begin
			state_q       <= state_d;
			loop_active_o <= (state_d == loop_fetch_pkg::S_LOOP);
		end
	end

	// ********************************************************************
	// Held instruction words
	// ********************************************************************
	// words are captured only while the loop is being formed, so they freeze inside it.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			decode_o <= loop_fetch_pkg::WORD_RST;
			queue_o  <= {loop_fetch_pkg::WORD_RST, loop_fetch_pkg::WORD_RST};
		end else if (ce_i) begin
			if (capture_l) begin
				decode_o <= fetch_i.word;
			end
			if (capture_b) begin
				queue_o[31:16] <= fetch_i.word;
			end
			if (capture_d) begin
				queue_o[15:0] <= fetch_i.word;
			end
		end
	end

	// ********************************************************************
	// Exit, exception and branch result pulses
	// ********************************************************************
	// refill after any exit except a reset operation, which restarts fetching itself.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			refill_o <= 1'b0;
		end else if (ce_i) begin
			refill_o <= exit_ev;
		end
	end

	// in loop mode interrupts are recognised at branch boundaries only; the looped instruction is skipped.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_take_o <= 1'b0;
		end else if (ce_i) begin
			irq_take_o <= irq_pend_i && !reset_op_i &&
				(br_i.exec || (loop_done_i && state_q != loop_fetch_pkg::S_LOOP));
		end
	end

	// trace after both the looped instruction and the branch.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			trace_take_o <= 1'b0;
		end else if (ce_i) begin
			trace_take_o <= trace_en_i && !reset_op_i && (loop_done_i || br_i.exec);
		end
	end

	// count kept at minus one, or when a false condition loops back.
	// A true condition discards the result unless the count reaches minus one, leaving the counter register untouched.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			br_res_o <= '0;
		end else if (ce_i) begin
			br_res_o.valid    <= br_i.exec;
			br_res_o.count    <= cnt_dec;
			br_res_o.taken    <= br_i.exec && br_taken;
			br_res_o.count_we <= br_i.exec &&
				((cnt_dec == loop_fetch_pkg::COUNT_END) || !br_i.cond_true);
		end
	end

	// ********************************************************************
	// Assertions
	// ********************************************************************
	property p_irq_after_branch;
		@(posedge clk_i) disable iff (!rst_b_i)
		(irq_take_o && $past(ce_i) && $past(loop_active_o)) |-> $past(br_i.exec);
	endproperty
	a_irq_after_branch: assert property (p_irq_after_branch)
		else $error("Interrupt taken in loop mode outside a branch boundary.");

	property p_irq_ends_loop;
		@(posedge clk_i) disable iff (!rst_b_i)
		(ce_i && loop_active_o && br_i.exec && irq_pend_i && !reset_op_i) |=>
			(!loop_active_o && irq_take_o && refill_o);
	endproperty
	a_irq_ends_loop: assert property (p_irq_ends_loop)
		else $error("Interrupt did not end loop mode.");

	property p_trace_blocks;
		@(posedge clk_i) disable iff (!rst_b_i)
		($past(trace_en_i) && !$past(loop_active_o)) |-> !loop_active_o;
	endproperty
	a_trace_blocks: assert property (p_trace_blocks)
		else $error("Loop mode engaged while tracing.");

	property p_reset_op_abort;
		@(posedge clk_i) disable iff (!rst_b_i)
		(ce_i && reset_op_i) |=> (!loop_active_o && state_q == loop_fetch_pkg::S_IDLE &&
			!refill_o && !irq_take_o);
	endproperty
	a_reset_op_abort: assert property (p_reset_op_abort)
		else $error("Reset operation did not abort loop processing.");

	property p_bus_err_exit;
		@(posedge clk_i) disable iff (!rst_b_i)
		(ce_i && bus_err_i && !reset_op_i && loop_active_o) |=> (!loop_active_o && refill_o);
	endproperty
	a_bus_err_exit: assert property (p_bus_err_exit)
		else $error("Bus error did not leave loop mode with a refill.");

	property p_count_write;
		@(posedge clk_i) disable iff (!rst_b_i)
		(ce_i && br_i.exec) |=> (br_res_o.valid &&
			br_res_o.count == $past(br_i.count) - loop_fetch_pkg::COUNT_STEP &&
			(br_res_o.count_we == ((br_res_o.count == loop_fetch_pkg::COUNT_END) ||
			!$past(br_i.cond_true))));
	endproperty
	a_count_write: assert property (p_count_write)
		else $error("Branch count result or write enable wrong.");

	property p_entry_words;
		@(posedge clk_i) disable iff (!rst_b_i)
		$rose(loop_active_o) |-> (queue_o[15:0] == loop_fetch_pkg::LOOP_DISP &&
			loop_fetch_pkg::is_dtb(queue_o[31:16]) && $past(state_q) == loop_fetch_pkg::S_REFETCH_B);
	endproperty
	a_entry_words: assert property (p_entry_words)
		else $error("Loop mode entered without a minus-four branch.");

	property p_words_held;
		@(posedge clk_i) disable iff (!rst_b_i)
		(loop_active_o && $past(loop_active_o)) |-> ($stable(decode_o) && $stable(queue_o));
	endproperty
	a_words_held: assert property (p_words_held)
		else $error("Held loop words changed inside loop mode.");

	property p_exit_refill;
		@(posedge clk_i) disable iff (!rst_b_i)
		$fell(loop_active_o) |-> (refill_o || $past(reset_op_i));
	endproperty
	a_exit_refill: assert property (p_exit_refill)
		else $error("Loop exit without a queue refill.");

	property p_stay_looping;
		@(posedge clk_i) disable iff (!rst_b_i)
		(ce_i && loop_active_o && !br_i.exec && !bus_err_i && !reset_op_i) |=> loop_active_o;
	endproperty
	a_stay_looping: assert property (p_stay_looping)
		else $error("Loop mode left without a terminating event.");

endmodule // loop_fetch_ctrl
`default_nettype wire

// File: bench/imem_model.sv
// Behavioural instruction memory that answers opcode fetches for the loop-mode bench.
`timescale 1ns/100ps
`default_nettype none
module imem_model (
	input  wire logic                    clk_i,
	input  wire logic                    rst_b_i,
	input  wire logic                    req_i,
	input  wire logic [1:0]              addr_i,
	input  wire logic                    slow_i,
	input  wire logic [15:0]             loop_word_i,
	input  wire logic [15:0]             disp_i,
	output loop_fetch_pkg::fetch_t       fetch_o
);
	logic [15:0] rd_d;
	logic        pend_q;
	logic [15:0] pend_word_q;

	// ****************************************************************
	// Program image
	// ****************************************************************
	// two-word branch layout
	always_comb begin
		case (addr_i)
			2'd0:    rd_d = loop_word_i;
			2'd1:    rd_d = 16'h57c8; // Branch opcode, counter in register zero.
			default: rd_d = disp_i;
		endcase
	end

	// A slow answer lands one cycle later; an idle bus toggles every cycle so that a
	// stale word can never pass for a fresh fetch.
	// normal opcode fetch
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pend_q      <= 1'b0;
			pend_word_q <= 16'h0000;
			fetch_o     <= '0;
		end else begin
			pend_q      <= req_i & slow_i;
			pend_word_q <= rd_d;
			if ((req_i & ~slow_i) | pend_q) begin
				fetch_o.valid <= 1'b1;
				fetch_o.word  <= pend_q ? pend_word_q : rd_d;
			end else begin
				fetch_o.valid <= 1'b0;
				fetch_o.word  <= ~fetch_o.word;
			end
		end
	end
endmodule // imem_model
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the loop-mode fetch controller with a memory model.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic                          clk_i = 1'b0;
	logic                          rst_b_i, ce_i, loop_done, irq_pend;
	logic                          trace_en, reset_op, bus_err, req, slow;
	logic [1:0]                    addr;
	logic [15:0]                   loop_word, disp;
	loop_fetch_pkg::branch_t       br;
	loop_fetch_pkg::fetch_t        fetch;
	logic                          loop_active, refill, irq_take, trace_take;
	logic [15:0]                   decode;
	logic [31:0]                   queue, rnd;
	loop_fetch_pkg::branch_res_t   br_res;
	loop_fetch_pkg::branch_res_t   exp_q[$];
	logic [15:0]                   elig[5] = '{16'h32d8, 16'hd058, 16'h4250, 16'he2d0, 16'hc108};
	int                            seed = 72;
	int                            n_fail = 0;
	int                            n_tests = 0;

	// 50 MHz clock.
	always #10 clk_i = ~clk_i;

	loop_fetch_ctrl uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .fetch_i(fetch),
		.br_i(br), .loop_done_i(loop_done), .irq_pend_i(irq_pend), .trace_en_i(trace_en),
		.reset_op_i(reset_op), .bus_err_i(bus_err), .loop_active_o(loop_active),
		.refill_o(refill), .irq_take_o(irq_take), .trace_take_o(trace_take),
		.decode_o(decode), .queue_o(queue), .br_res_o(br_res));
	imem_model mem (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req), .addr_i(addr),
		.slow_i(slow), .loop_word_i(loop_word), .disp_i(disp), .fetch_o(fetch));

	// ****************************************************************
	// Checks and verdict
	// ****************************************************************
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// The count is only meaningful when it is written back, so a discard skips it.
	task automatic chk_res(input loop_fetch_pkg::branch_res_t got,
		input loop_fetch_pkg::branch_res_t exp);
		n_tests++;
		if (got.valid !== 1'b1 || got.count_we !== exp.count_we || got.taken !== exp.taken
			|| (exp.count_we && got.count !== exp.count)) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic loop_fetch_pkg::branch_res_t exp_res(input logic [15:0] c,
		input logic cond);
		loop_fetch_pkg::branch_res_t r;
		r.valid = 1'b1;
		r.count = c - loop_fetch_pkg::COUNT_STEP;
		r.count_we = (r.count == loop_fetch_pkg::COUNT_END) || !cond;
		r.taken = (r.count != loop_fetch_pkg::COUNT_END) && !cond;
		return r;
	endfunction

	// Each branch result is matched against the oldest note.
	always @(posedge clk_i) begin
		if (br_res.valid === 1'b1) begin
			if (exp_q.size() == 0) chk(32'h0000_0001, 32'h0000_0000);
			else chk_res(br_res, exp_q.pop_front());
		end
	end

	// ****************************************************************
	// Drivers
	// ****************************************************************
	function automatic logic [15:0] rnd_count();
		rnd = $random(seed);
		return {1'b0, rnd[14:1], 1'b1};
	endfunction

	task automatic fet(input logic [1:0] a);
		@(posedge clk_i);
		rnd = $random(seed);
		req  <= 1'b1;
		addr <= a;
		slow <= rnd[0];
		@(posedge clk_i);
		req <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	// Kind 0 is loop done, 1 bus error, 2 reset operation.
	task automatic ev(input int k);
		@(posedge clk_i);
		loop_done <= (k == 0);
		bus_err   <= (k == 1);
		reset_op  <= (k == 2);
		@(posedge clk_i);
		loop_done <= 1'b0;
		bus_err   <= 1'b0;
		reset_op  <= 1'b0;
		#1;
	endtask

	task automatic brx(input logic [15:0] c, input logic cond);
		@(posedge clk_i);
		exp_q.push_back(exp_res(c, cond));
		br <= '{exec: 1'b1, cond_true: cond, count: c};
		@(posedge clk_i);
		br.exec <= 1'b0;
		#1;
	endtask

	task automatic enter(input logic [15:0] w, input logic [15:0] d, input logic cond,
		input logic exp);
		// A reset operation first clears any half-formed sequence of the last scenario.
		ev(2);
		loop_word = w;
		disp = d;
		fet(2'd0);
		fet(2'd1);
		fet(2'd2);
		brx(rnd_count(), cond);
		chk(trace_take, trace_en);
		fet(2'd0);
		#1 chk(loop_active, 1'b0);
		fet(2'd1);
		#1 chk(loop_active, exp);
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{rst_b_i, loop_done, irq_pend, trace_en, reset_op, bus_err, req, slow} = '0;
		{addr, loop_word, disp, br} = '0;
		ce_i = 1'b1;
		repeat (16) @(posedge clk_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			enter(elig[i], loop_fetch_pkg::LOOP_DISP, 1'b0, 1'b1);
			chk(decode, elig[i]);
			chk(queue, {16'h57c8, loop_fetch_pkg::LOOP_DISP});
			ev(0);
			brx(rnd_count(), 1'b0);
			chk(loop_active, 1'b1);
			case (i)
				0: brx(16'h0000, 1'b0);
				1: brx(rnd_count(), 1'b1);
				2: begin
					@(posedge clk_i) irq_pend <= 1'b1;
					ev(0);
					chk(irq_take, 1'b0);
					brx(rnd_count(), 1'b0);
					chk(irq_take, 1'b1);
				end
				3: begin
					// A bus error while the enable is low must be ignored.
					@(posedge clk_i) ce_i <= 1'b0;
					ev(1);
					chk(loop_active, 1'b1);
					@(posedge clk_i) ce_i <= 1'b1;
					ev(1);
				end
				default: ev(2);
			endcase
			chk(loop_active, 1'b0);
			chk(refill, i != 4);
			@(posedge clk_i) irq_pend <= 1'b0;
		end
		@(posedge clk_i) irq_pend <= 1'b1;
		ev(0);
		chk(irq_take, 1'b1);
		@(posedge clk_i) irq_pend <= 1'b0;
		enter(16'h3200, loop_fetch_pkg::LOOP_DISP, 1'b0, 1'b0);
		enter(16'h3028, loop_fetch_pkg::LOOP_DISP, 1'b0, 1'b0);
		enter(16'h32d8, 16'hfffa, 1'b0, 1'b0);
		enter(16'h32d8, loop_fetch_pkg::LOOP_DISP, 1'b1, 1'b0);
		@(posedge clk_i) trace_en <= 1'b1;
		ev(0);
		chk(trace_take, 1'b1);
		enter(16'h32d8, loop_fetch_pkg::LOOP_DISP, 1'b0, 1'b0);
		@(posedge clk_i) trace_en <= 1'b0;
		for (int k = 0; k < 20 && exp_q.size() > 0; k++) @(posedge clk_i);
		if (exp_q.size() > 0) n_fail++;
		complete_run();
	end

	// A hang is cut short and counted.
	initial begin
		repeat (100000) @(posedge clk_i);
		n_fail++;
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
